// ===== cms_core.sv
// Stack save/restore execution core with APB register port.
// Assumes a stack memory that takes a write on its one-cycle write strobe
// and returns read data exactly two cycles after its one-cycle read strobe.
//
// Operation
// RULE1 - Save writes pair's upper byte at stack_pointer minus one.
// RULE2 - Save writes pair's lower byte at stack_pointer minus two.
// RULE3 - Save lowers stack_pointer by exactly two.
// RULE4 - Software never selects stack_pointer as the save/restore pair.
// RULE5 - Pair save takes 3 machine cycles, 11 states, flags unchanged.
// RULE6 - Accumulator save writes accumulator at stack_pointer minus one.
// RULE7 - Accumulator save writes packed flag byte at stack_pointer minus two.
// RULE8 - Flag byte: S7 Z6 0 AC4 0 P2 1 CY0.
// RULE9 - Accumulator save lowers stack_pointer by two.
// RULE10 - Pair restore loads lower register from byte at stack_pointer.
// RULE11 - Pair restore loads upper register from stack_pointer plus one.
// RULE12 - Every restore raises stack_pointer by exactly two.
// RULE13 - Accumulator restore reloads flags from bits 0,2,4,6,7.
// RULE14 - Accumulator restore loads accumulator from stack_pointer plus one.
// RULE15 - Flags untouched except by accumulator-with-flags restore.
// RULE16 - Pair field 00,01,10 picks pairs; 11 picks accumulator with flags.
// RULE17 - Saves write upper then lower; restores read lower then upper.
`timescale 1ns/1ps
module cms_core (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [15:0] mem_addr,
    output logic      [7:0]  mem_wdata,
    output logic             mem_wr,
    output logic             mem_rd,
    input  wire logic [7:0]  mem_rdata,
    output logic             busy,
    output logic             exec_done
);

    cms_pkg::cms_core_s core_reg;
    cms_pkg::cms_core_s core_next;

    logic       setup;
    logic       access;
    logic       mapped;
    logic [7:0] off;
    logic [3:0] cnt_inc;
    logic [3:0] m1;
    logic [3:0] strobe_a;
    logic [3:0] strobe_b;
    logic [3:0] last;
    logic [15:0] pair_val;
    logic [7:0] flag_byte;

    assign off    = paddr[7:0];
    assign setup  = psel & ~penable;
    assign access = psel & penable;
    assign mapped = (paddr[31:8] == 24'h00_0000) &&
                    (off == cms_pkg::CMS_OFF_CMD ||
                     off == cms_pkg::CMS_OFF_STATUS ||
                     off == cms_pkg::CMS_OFF_SP ||
                     off == cms_pkg::CMS_OFF_BC ||
                     off == cms_pkg::CMS_OFF_DE ||
                     off == cms_pkg::CMS_OFF_HL ||
                     off == cms_pkg::CMS_OFF_AF);

    // Register writes while an instruction runs would race the core
    assign pready  = 1'b1;
    assign pslverr = access & (~mapped |
                     (pwrite & (core_reg.fsm == cms_pkg::CMS_EXEC)));

    assign prdata    = core_reg.prdata;
    assign mem_addr  = core_reg.mem.addr;
    assign mem_wdata = core_reg.mem.wdata;
    assign mem_wr    = core_reg.mem.wr;
    assign mem_rd    = core_reg.mem.rd;
    assign busy      = (core_reg.fsm == cms_pkg::CMS_EXEC);
    assign exec_done = core_reg.done;

    // Fixed bits are forced whenever the flag byte is formed
    function automatic logic [7:0] pack_flags(input logic [7:0] f);
        logic [7:0] r;
        r = f;
        r[cms_pkg::CMS_FB_ZERO5] = 1'b0;                      // [RULE8]
        r[cms_pkg::CMS_FB_ZERO3] = 1'b0;                      // [RULE8]
        r[cms_pkg::CMS_FB_ONE]   = 1'b1;                      // [RULE8]
        return r;
    endfunction : pack_flags

    // Machine cycle timing: fetch cycle, then two 3-state memory cycles
    assign m1       = core_reg.restore ? cms_pkg::CMS_REST_M1
                                       : cms_pkg::CMS_SAVE_M1;
    assign strobe_a = m1;
    assign strobe_b = m1 + cms_pkg::CMS_MC_STATES;
    assign last     = (core_reg.restore ? cms_pkg::CMS_REST_STATES
                                        : cms_pkg::CMS_SAVE_STATES) - 4'h1;
    assign cnt_inc  = core_reg.cnt + 4'h1;
    assign flag_byte = pack_flags(core_reg.flags);

    always_comb begin
        case (core_reg.sel)                                   // [RULE16]
            cms_pkg::CMS_SEL_BC: pair_val = core_reg.bc;
            cms_pkg::CMS_SEL_DE: pair_val = core_reg.de;
            cms_pkg::CMS_SEL_HL: pair_val = core_reg.hl;
            default:             pair_val = {core_reg.acc, flag_byte};
        endcase
    end

    always_comb begin
        core_next        = core_reg;
        core_next.done   = 1'b0;
        core_next.mem.wr = 1'b0;
        core_next.mem.rd = 1'b0;

        if (setup) begin
            case (off)
                cms_pkg::CMS_OFF_CMD:
                    core_next.prdata = {24'h00_0000, core_reg.opcode};
                cms_pkg::CMS_OFF_STATUS:
                    core_next.prdata = {30'h0000_0000, core_reg.illegal,
                                        busy};
                cms_pkg::CMS_OFF_SP:
                    core_next.prdata = {16'h0000, core_reg.sp};
                cms_pkg::CMS_OFF_BC:
                    core_next.prdata = {16'h0000, core_reg.bc};
                cms_pkg::CMS_OFF_DE:
                    core_next.prdata = {16'h0000, core_reg.de};
                cms_pkg::CMS_OFF_HL:
                    core_next.prdata = {16'h0000, core_reg.hl};
                cms_pkg::CMS_OFF_AF:
                    core_next.prdata = {16'h0000, core_reg.acc, flag_byte};
                default:
                    core_next.prdata = 32'h0000_0000;
            endcase
        end

        case (core_reg.fsm)
            cms_pkg::CMS_IDLE: begin
                if (access && pwrite && mapped) begin
                    case (off)
                        cms_pkg::CMS_OFF_CMD: begin
                            core_next.opcode  = pwdata[7:0];
                            core_next.sel     = pwdata[5:4];
                            core_next.restore =
                                (pwdata[3:0] == cms_pkg::CMS_OP_RESTORE);
                            core_next.cnt     = 4'h0;
                            if (pwdata[7:6] == cms_pkg::CMS_OP_TOP &&
                                (pwdata[3:0] == cms_pkg::CMS_OP_SAVE ||
                                 pwdata[3:0] == cms_pkg::CMS_OP_RESTORE))
                            begin
                                core_next.fsm     = cms_pkg::CMS_EXEC;
                                core_next.illegal = 1'b0;
                            end else begin
                                core_next.illegal = 1'b1;
                            end
                        end
                        cms_pkg::CMS_OFF_STATUS:
                            core_next.illegal = core_reg.illegal &
                                ~pwdata[cms_pkg::CMS_ST_ILLEGAL];
                        cms_pkg::CMS_OFF_SP: core_next.sp = pwdata[15:0];
                        cms_pkg::CMS_OFF_BC: core_next.bc = pwdata[15:0];
                        cms_pkg::CMS_OFF_DE: core_next.de = pwdata[15:0];
                        cms_pkg::CMS_OFF_HL: core_next.hl = pwdata[15:0];
                        cms_pkg::CMS_OFF_AF: begin
                            core_next.acc   = pwdata[15:8];
                            core_next.flags = pack_flags(pwdata[7:0]);
                        end
                        default: core_next.opcode = core_reg.opcode;
                    endcase
                end
            end
            cms_pkg::CMS_EXEC: begin
                core_next.cnt = cnt_inc;
                if (!core_reg.restore) begin
                    // Upper byte goes out first, its own write cycle
                    if (cnt_inc == strobe_a) begin            // [RULE17]
                        core_next.mem.wr    = 1'b1;
                        core_next.mem.addr  = core_reg.sp - 16'h0001; // [RULE1] [RULE6]
                        core_next.mem.wdata = pair_val[15:8];
                    end
                    if (cnt_inc == strobe_b) begin            // [RULE17]
                        core_next.mem.wr    = 1'b1;
                        core_next.mem.addr  = core_reg.sp - 16'h0002; // [RULE2] [RULE7]
                        core_next.mem.wdata = pair_val[7:0];
                    end
                end else begin
                    if (cnt_inc == strobe_a) begin            // [RULE17]
                        core_next.mem.rd   = 1'b1;
                        core_next.mem.addr = core_reg.sp;     // [RULE10]
                    end
                    if (cnt_inc == strobe_b) begin
                        core_next.mem.rd   = 1'b1;
                        core_next.mem.addr = core_reg.sp + 16'h0001; // [RULE11] [RULE14]
                    end
                    if (core_reg.cnt == strobe_a + cms_pkg::CMS_RD_LATENCY)
                        core_next.low_byte = mem_rdata;
                end
                // Flags change only on the accumulator restore
                if (core_reg.cnt == last) begin               // [RULE5] [RULE15]
                    core_next.fsm  = cms_pkg::CMS_IDLE;
                    core_next.done = 1'b1;
                    if (!core_reg.restore) begin
                        core_next.sp = core_reg.sp - 16'h0002; // [RULE3] [RULE9]
                    end else begin
                        core_next.sp = core_reg.sp + 16'h0002; // [RULE12]
                        case (core_reg.sel)                   // [RULE16]
                            cms_pkg::CMS_SEL_BC:
                                core_next.bc = {mem_rdata, core_reg.low_byte};
                            cms_pkg::CMS_SEL_DE:
                                core_next.de = {mem_rdata, core_reg.low_byte};
                            cms_pkg::CMS_SEL_HL:
                                core_next.hl = {mem_rdata, core_reg.low_byte};
                            default: begin
                                core_next.acc   = mem_rdata;  // [RULE14]
                                core_next.flags =
                                    pack_flags(core_reg.low_byte); // [RULE13]
                            end
                        endcase
                    end
                end
            end
            default: core_next.fsm = cms_pkg::CMS_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_reg.fsm      <= cms_pkg::CMS_IDLE;
            core_reg.cnt      <= 4'h0;
            core_reg.restore  <= 1'b0;
            core_reg.sel      <= 2'h0;
            core_reg.opcode   <= cms_pkg::CMS_RST_OP;
            core_reg.illegal  <= 1'b0;
            core_reg.done     <= 1'b0;
            core_reg.sp       <= cms_pkg::CMS_RST_SP;
            core_reg.bc       <= cms_pkg::CMS_RST_PAIR;
            core_reg.de       <= cms_pkg::CMS_RST_PAIR;
            core_reg.hl       <= cms_pkg::CMS_RST_PAIR;
            core_reg.acc      <= cms_pkg::CMS_RST_ACC;
            core_reg.flags    <= cms_pkg::CMS_RST_FLAGS;
            core_reg.low_byte <= 8'h00;
            core_reg.mem      <= '0;
            core_reg.prdata   <= 32'h0000_0000;
        end else begin
            core_reg <= core_next;
        end
    end

endmodule : cms_core

// ===== cms_pkg.sv
// Constants and types for the stack save/restore execution core.
// Assumes a single 100 MHz clock and an APB register port.
package cms_pkg;

    // APB byte offsets
    localparam logic [7:0] CMS_OFF_CMD    = 8'h00;
    localparam logic [7:0] CMS_OFF_STATUS = 8'h04;
    localparam logic [7:0] CMS_OFF_SP     = 8'h08;
    localparam logic [7:0] CMS_OFF_BC     = 8'h0C;
    localparam logic [7:0] CMS_OFF_DE     = 8'h10;
    localparam logic [7:0] CMS_OFF_HL     = 8'h14;
    localparam logic [7:0] CMS_OFF_AF     = 8'h18;

    // Status bits
    localparam int CMS_ST_BUSY    = 0;
    localparam int CMS_ST_ILLEGAL = 1;

    // Opcode fields: 11 pp 0101 save, 11 pp 0001 restore
    localparam logic [1:0] CMS_OP_TOP     = 2'h3;
    localparam logic [3:0] CMS_OP_SAVE    = 4'h5;
    localparam logic [3:0] CMS_OP_RESTORE = 4'h1;
    localparam logic [1:0] CMS_SEL_BC     = 2'h0;
    localparam logic [1:0] CMS_SEL_DE     = 2'h1;
    localparam logic [1:0] CMS_SEL_HL     = 2'h2;
    localparam logic [1:0] CMS_SEL_AF     = 2'h3;

    // Packed status byte layout
    localparam int CMS_FB_CARRY = 0;
    localparam int CMS_FB_ONE   = 1;
    localparam int CMS_FB_PAR   = 2;
    localparam int CMS_FB_ZERO3 = 3;
    localparam int CMS_FB_HALF  = 4;
    localparam int CMS_FB_ZERO5 = 5;
    localparam int CMS_FB_ZERO  = 6;
    localparam int CMS_FB_SIGN  = 7;

    // Clock states per instruction and per machine cycle
    localparam logic [3:0] CMS_SAVE_STATES = 4'hB;
    localparam logic [3:0] CMS_REST_STATES = 4'hA;
    localparam logic [3:0] CMS_SAVE_M1     = 4'h5;
    localparam logic [3:0] CMS_REST_M1     = 4'h4;
    localparam logic [3:0] CMS_MC_STATES   = 4'h3;
    localparam logic [3:0] CMS_RD_LATENCY  = 4'h2;

    // Reset values
    localparam logic [15:0] CMS_RST_SP    = 16'h0000;
    localparam logic [15:0] CMS_RST_PAIR  = 16'h0000;
    localparam logic [7:0]  CMS_RST_ACC   = 8'h00;
    localparam logic [7:0]  CMS_RST_FLAGS = 8'h02;
    localparam logic [7:0]  CMS_RST_OP    = 8'h00;

    typedef enum logic [1:0] {
        CMS_IDLE = 2'b01,
        CMS_EXEC = 2'b10
    } cms_state_e;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } cms_mem_s;

    typedef struct packed {
        cms_state_e  fsm;
        logic [3:0]  cnt;
        logic        restore;
        logic [1:0]  sel;
        logic [7:0]  opcode;
        logic        illegal;
        logic        done;
        logic [15:0] sp;
        logic [15:0] bc;
        logic [15:0] de;
        logic [15:0] hl;
        logic [7:0]  acc;
        logic [7:0]  flags;
        logic [7:0]  low_byte;
        cms_mem_s    mem;
        logic [31:0] prdata;
    } cms_core_s;

endpackage : cms_pkg

// ===== cms_core_properties.sv
// Port-level checks for the stack save/restore core.
// Assumes binding to cms_core; one clock, reset active low.
`timescale 1ns/1ps
module cms_core_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0]  mem_wdata,
    input wire logic        mem_wr,
    input wire logic        mem_rd,
    input wire logic [7:0]  mem_rdata,
    input wire logic        busy,
    input wire logic        exec_done
);
    logic go;
    logic sv;
    logic rs;
    assign go = psel && penable && pwrite && !busy && paddr == 32'h0000_0000
                && pwdata[7:6] == cms_pkg::CMS_OP_TOP;
    assign sv = go && pwdata[3:0] == cms_pkg::CMS_OP_SAVE;
    assign rs = go && pwdata[3:0] == cms_pkg::CMS_OP_RESTORE;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_save_len;
        sv |-> ##12 exec_done;
    endproperty
    a_save_len: assert property (p_save_len)
        else $error("save did not finish in eleven states");
    property p_rest_len;
        rs |-> ##11 exec_done;
    endproperty
    a_rest_len: assert property (p_rest_len)
        else $error("restore did not finish in ten states");
    property p_save_order;
        logic [15:0] a;
        sv |-> ##6 (mem_wr, a = mem_addr) ##3 (mem_wr && mem_addr == a - 16'h1);
    endproperty
    a_save_order: assert property (p_save_order)
        else $error("save writes out of place or order");
    property p_rest_order;
        logic [15:0] a;
        rs |-> ##5 (mem_rd, a = mem_addr) ##3 (mem_rd && mem_addr == a + 16'h1);
    endproperty
    a_rest_order: assert property (p_rest_order)
        else $error("restore reads out of place or order");
    property p_strobe_busy;
        (mem_wr || mem_rd) |-> busy;
    endproperty
    a_strobe_busy: assert property (p_strobe_busy)
        else $error("memory strobe outside an instruction");
    property p_done;
        exec_done |-> !busy && $past(busy);
    endproperty
    a_done: assert property (p_done)
        else $error("done pulse not at end of busy");
    property p_rest_nowr;
        rs |-> ##1 (!mem_wr)[*8] ##1 (!mem_wr)[*3];
    endproperty
    a_rest_nowr: assert property (p_rest_nowr)
        else $error("restore wrote memory");
    property p_af_byte;
        sv && pwdata[5:4] == cms_pkg::CMS_SEL_AF |-> ##9
            (mem_wdata[1] && !mem_wdata[3] && !mem_wdata[5]);
    endproperty
    a_af_byte: assert property (p_af_byte)
        else $error("flag byte fixed bits wrong");
endmodule : cms_core_properties

bind cms_core cms_core_properties i_props (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_addr,
    .mem_wdata, .mem_wr, .mem_rd, .mem_rdata, .busy, .exec_done);

// ===== cms_stack_mem.sv
// Behavioural stack memory on the far side of the core.
// Assumes one-cycle strobes; read data valid two cycles after mem_rd.
`timescale 1ns/1ps
module cms_stack_mem (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [15:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    input  wire logic        mem_wr,
    input  wire logic        mem_rd,
    output logic      [7:0]  mem_rdata
);
    logic [7:0] mem [0:65535];
    logic       rd_pend;

    // Outside the valid cycle the bus flips, so stale data never passes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_pend   <= 1'b0;
            mem_rdata <= 8'h00;
        end else begin
            rd_pend   <= mem_rd;
            mem_rdata <= rd_pend ? mem[mem_addr] : ~mem_rdata;
            if (mem_wr) begin
                mem[mem_addr] <= mem_wdata;
            end
        end
    end
endmodule : cms_stack_mem

// ===== tb_top.sv
// Self-checking bench for the stack save/restore core.
// Assumes cms_core, its bound checker and the stack memory model.
`timescale 1ns/1ps
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [15:0] mem_addr, sp_exp, v;
    logic [7:0]  mem_wdata, mem_rdata;
    logic        mem_wr, mem_rd, busy, exec_done, er;
    logic [15:0] pair_exp [4];
    logic [1:0]  s, r;
    int          err_count, check_count;

    cms_core i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .mem_addr, .mem_wdata,
        .mem_wr, .mem_rd, .mem_rdata, .busy, .exec_done);
    cms_stack_mem i_mem (.pclk, .presetn, .mem_addr, .mem_wdata, .mem_wr,
        .mem_rd, .mem_rdata);

    function automatic logic [15:0] fix(input logic [1:0] sl,
                                        input logic [15:0] d);
        fix = (sl == cms_pkg::CMS_SEL_AF) ? ((d & 16'hffd7) | 16'h0002) : d;
    endfunction : fix

    function automatic logic [7:0] off(input logic [1:0] sl);
        off = cms_pkg::CMS_OFF_BC + {4'h0, sl, 2'b00};
    endfunction : off

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        logic rdy;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {24'h0, a};
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // Sample settled outputs in the cycle that the edge closes
        do begin
            @(negedge pclk);
            n++;
            rdy = pready;
            rd  = prdata;
            er  = pslverr;
            @(posedge pclk);
        end while (rdy !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_done();
        int n;
        n = 0;
        // Pulse is looked at mid-cycle, away from the launching edge
        do begin
            @(negedge pclk);
            n++;
        end while (exec_done !== 1'b1 && n < 40);
        check(32'(n < 40), 32'h1);
    endtask : wait_done

    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        print_verdict();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        err_count = 0;
        check_count = 0;
        void'($urandom(32'hc39f_4719));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, cms_pkg::CMS_OFF_AF, 32'h0);
        check(rd, 32'h0000_0002);
        for (int i = 0; i < 4; i++) begin
            v = 16'($urandom);
            pair_exp[i] = fix(2'(i), v);
            apb(1'b1, off(2'(i)), {16'h0, v});
        end
        for (int k = 0; k < 12; k++) begin
            // Selector only reaches pairs and flag word
            s = 2'(k);
            r = 2'($urandom);
            // First pass wraps the stack pointer through zero
            sp_exp = (k == 0) ? 16'h0001 : 16'($urandom);
            apb(1'b1, cms_pkg::CMS_OFF_SP, {16'h0, sp_exp});
            apb(1'b1, cms_pkg::CMS_OFF_CMD, {24'h0, 2'b11, s, 4'h5});
            apb(1'b1, cms_pkg::CMS_OFF_SP, 32'h0);
            check(32'(er), 32'h1);
            apb(1'b0, cms_pkg::CMS_OFF_STATUS, 32'h0);
            check(32'(rd[0]), 32'h1);
            wait_done();
            check(i_mem.mem[sp_exp - 16'h1], pair_exp[s][15:8]);
            check(i_mem.mem[sp_exp - 16'h2], pair_exp[s][7:0]);
            sp_exp = sp_exp - 16'h2;
            apb(1'b0, cms_pkg::CMS_OFF_SP, 32'h0);
            check(rd, {16'h0, sp_exp});
            apb(1'b1, cms_pkg::CMS_OFF_CMD, {24'h0, 2'b11, r, 4'h1});
            wait_done();
            pair_exp[r] = fix(r, pair_exp[s]);
            sp_exp = sp_exp + 16'h2;
            for (int j = 0; j < 4; j++) begin
                apb(1'b0, off(2'(j)), 32'h0);
                check(rd, {16'h0, pair_exp[j]});
            end
            apb(1'b0, cms_pkg::CMS_OFF_SP, 32'h0);
            check(rd, {16'h0, sp_exp});
        end
        apb(1'b1, cms_pkg::CMS_OFF_CMD, 32'h0);
        apb(1'b0, cms_pkg::CMS_OFF_STATUS, 32'h0);
        check(rd, 32'h0000_0002);
        apb(1'b1, cms_pkg::CMS_OFF_STATUS, 32'h0000_0002);
        apb(1'b0, cms_pkg::CMS_OFF_STATUS, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h1c, 32'h0);
        check({31'h0, er}, 32'h1);
        check(rd, 32'h0);
        print_verdict();
    end
endmodule : tb_top
